// >>> inc/rmir_pkg.sv
`default_nettype none
package rmir_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_W = 6;

   // Register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CHIP_MODE_FIRST = 6'h02;
   localparam logic [IDX_W-1:0] IDX_CHIP_MODE_SECOND = 6'h03;
   localparam logic [IDX_W-1:0] IDX_PENDING_FLAGS = 6'h04;
   localparam logic [IDX_W-1:0] IDX_SUPPRESS_BITS = 6'h05;
   localparam logic [IDX_W-1:0] IDX_CHANNEL_FOUND = 6'h06;
   localparam logic [IDX_W-1:0] IDX_POLLING_CTRL = 6'h07;

   // First chip mode register fields
   localparam int unsigned BIT_OPERATING_MODE = 0;

   // Second chip mode register fields
   localparam int unsigned BIT_CONFIG_HOLD = 6;
   localparam int unsigned BIT_IRQ_POLARITY = 5;
   localparam int unsigned BIT_XTAL_TRIM = 4;
   localparam int unsigned BIT_QUEUE_INIT = 3;
   localparam int unsigned BIT_CLK_DATA_SEL = 2;
   localparam int unsigned BIT_IRQ_STROBE_SEL = 1;
   localparam int unsigned BIT_RUN_DATA_SEL = 0;

   // Polling control fields
   localparam int unsigned BIT_CONT_SEARCH = 3;
   localparam int unsigned BIT_ACTIVE_IDLE = 2;
   localparam int unsigned SCHEME_MSB = 1;
   localparam int unsigned SCHEME_LSB = 0;

   // Polling schemes
   localparam logic [1:0] SCHEME_CONST_ON_OFF = 2'h0;
   localparam logic [1:0] SCHEME_FAST_FALLBACK = 2'h1;
   localparam logic [1:0] SCHEME_MIXED = 2'h2;
   localparam logic [1:0] SCHEME_RESERVED = 2'h3;

   // Reset values
   localparam logic [7:0] RST_CHIP_MODE_FIRST = 8'h00;
   localparam logic [7:0] RST_CHIP_MODE_SECOND = 8'h00;
   localparam logic [7:0] RST_PENDING_FLAGS = 8'hff;
   localparam logic [7:0] RST_SUPPRESS_BITS = 8'h00;
   localparam logic [1:0] RST_CHANNEL_CODE = 2'h0;
   localparam logic [7:0] RST_POLLING_CTRL = 8'h00;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Event flags, bit 7 down to bit 0
   typedef struct packed {
      logic message_end_cfg_b;
      logic message_id_hit_cfg_b;
      logic frame_sync_cfg_b;
      logic wakeup_hit_cfg_b;
      logic message_end_cfg_a;
      logic message_id_hit_cfg_a;
      logic frame_sync_cfg_a;
      logic wakeup_hit_cfg_a;
   } rmir_evt_s;

   // Shared pin drives
   typedef struct packed {
      logic clock_or_data;
      logic interrupt_or_strobe;
      logic running_or_data;
   } rmir_pins_s;

   // Mode controls towards the receiver core
   typedef struct packed {
      logic config_hold;
      logic crystal_trim_enable;
      logic queue_init_pulse;
      logic continuous_wakeup_search;
      logic polling_active_idle_enable;
      logic [1:0] polling_scheme;
      logic operating_mode_select;
   } rmir_ctrl_s;

   // Write channel states, gray along idle-addr-resp
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_HAVE_ADDR = 2'b01,
      WR_RESP = 2'b11,
      WR_HAVE_DATA = 2'b10
   } rmir_wr_state_e;

   typedef enum logic {
      RD_IDLE = 1'b0,
      RD_DATA = 1'b1
   } rmir_rd_state_e;

   // Whole state of the block
   typedef struct packed {
      rmir_wr_state_e wr_state;
      logic [IDX_W-1:0] wr_idx;
      logic [7:0] wr_data;
      logic wr_strobe;
      logic [1:0] bresp;
      rmir_rd_state_e rd_state;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
      logic [7:0] chip_mode_first;
      logic [7:0] chip_mode_second;
      rmir_evt_s pending_flags;
      logic [7:0] suppress_bits;
      logic [1:0] channel_code;
      logic [7:0] polling_ctrl;
      rmir_pins_s pins;
      rmir_ctrl_s ctrl;
   } rmir_state_s;

endpackage
`default_nettype wire

// >>> hdl/rmir_regs.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Hold bit freezes config state in slave mode
// - Polarity bit selects interrupt active low/high
// - Trim enable bit drives crystal trimming
// - Queue init bit reinitialises FIFO per frame
// - Bit 2 muxes clock output or data
// - Bit 1 muxes interrupt or data strobe
// - Bit 0 muxes running flag or data
// - Reset sets all pending flags to one
// - Config B events high nibble, A low
// - Suppress bit one masks event, resets zero
// - Suppress bits align with pending flag bits
// - Channel code updates on polling wake-up
// - Channel code zero none, else channel
// - Bit 3 enables continuous wake-up search
// - Bit 2 enables polling active idle
// - Scheme field selects polling scheme
// - Mode bit selects slave or self-polling
module rmir_regs (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // AXI4-Lite write address
   input wire logic [rmir_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [rmir_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [rmir_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [rmir_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Events and signals from the receiver core
   input wire rmir_pkg::rmir_evt_s event_pulse,
   input wire logic wakeup_found,
   input wire logic [1:0] wakeup_channel,
   input wire logic frame_start,
   input wire logic clock_output_src,
   input wire logic rx_data,
   input wire logic rx_data_strobe,
   input wire logic rx_running,
   // Controls to the receiver core
   output rmir_pkg::rmir_ctrl_s mode_ctrl,
   // Shared output pins
   output rmir_pkg::rmir_pins_s pin_drive
);
   import rmir_pkg::*;

   rmir_state_s st_r;
   rmir_state_s st_nxt;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [IDX_W-1:0] ar_idx;
   logic irq_level;
   logic irq_pin_level;
   logic [7:0] cms;
   logic [7:0] pol;

   // Handshakes, nothing is taken while frozen
   assign s_axi_awready = clk_en && (st_r.wr_state == WR_IDLE || st_r.wr_state == WR_HAVE_DATA);
   assign s_axi_wready = clk_en && (st_r.wr_state == WR_IDLE || st_r.wr_state == WR_HAVE_ADDR);
   assign s_axi_bvalid = (st_r.wr_state == WR_RESP);
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = clk_en && (st_r.rd_state == RD_IDLE);
   assign s_axi_rvalid = (st_r.rd_state == RD_DATA);
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rdata = st_r.rdata;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign ar_idx = s_axi_araddr[IDX_LSB +: IDX_W];

   // Registered outputs
   assign mode_ctrl = st_r.ctrl;
   assign pin_drive = st_r.pins;

   // Interrupt level from unmasked pending flags
   assign cms = st_r.chip_mode_second;
   assign pol = st_r.polling_ctrl;
   assign irq_level = |(st_r.pending_flags & ~st_r.suppress_bits);
   assign irq_pin_level = cms[BIT_IRQ_POLARITY] ? irq_level : ~irq_level;

   // Next state of the whole block
   always_comb begin
      st_nxt = st_r;
      if (clk_en) begin
         // Write address and data in either order
         case (st_r.wr_state)
            WR_IDLE: begin
               if (aw_take && w_take) begin
                  st_nxt.wr_state = WR_RESP;
               end else if (aw_take) begin
                  st_nxt.wr_state = WR_HAVE_ADDR;
               end else if (w_take) begin
                  st_nxt.wr_state = WR_HAVE_DATA;
               end
            end
            WR_HAVE_ADDR: begin
               if (w_take) begin
                  st_nxt.wr_state = WR_RESP;
               end
            end
            WR_HAVE_DATA: begin
               if (aw_take) begin
                  st_nxt.wr_state = WR_RESP;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  st_nxt.wr_state = WR_IDLE;
               end
            end
            default: begin
               st_nxt.wr_state = WR_IDLE;
            end
         endcase
         if (aw_take) begin
            st_nxt.wr_idx = s_axi_awaddr[IDX_LSB +: IDX_W];
         end
         if (w_take) begin
            st_nxt.wr_data = s_axi_wdata[7:0];
            st_nxt.wr_strobe = s_axi_wstrb[0];
         end

         // Commit the write on the edge both halves are held
         if (st_nxt.wr_state == WR_RESP && st_r.wr_state != WR_RESP) begin
            st_nxt.bresp = RESP_OKAY;
            case (st_nxt.wr_idx)
               IDX_CHIP_MODE_FIRST: begin
                  if (st_nxt.wr_strobe) begin
                     st_nxt.chip_mode_first = st_nxt.wr_data;
                  end
               end
               IDX_CHIP_MODE_SECOND: begin
                  if (st_nxt.wr_strobe) begin
                     st_nxt.chip_mode_second = st_nxt.wr_data;
                  end
               end
               IDX_SUPPRESS_BITS: begin
                  if (st_nxt.wr_strobe) begin
                     st_nxt.suppress_bits = st_nxt.wr_data;
                  end
               end
               IDX_POLLING_CTRL: begin
                  if (st_nxt.wr_strobe) begin
                     st_nxt.polling_ctrl = st_nxt.wr_data;
                  end
               end
               IDX_PENDING_FLAGS, IDX_CHANNEL_FOUND: begin
                  st_nxt.bresp = RESP_OKAY; // Read-only, write ignored
               end
               default: begin
                  st_nxt.bresp = RESP_SLVERR;
               end
            endcase
         end

         // Read channel, data latched at the address handshake
         case (st_r.rd_state)
            RD_IDLE: begin
               if (ar_take) begin
                  st_nxt.rd_state = RD_DATA;
                  st_nxt.rdata = '0;
                  st_nxt.rresp = RESP_OKAY;
                  case (ar_idx)
                     IDX_PENDING_FLAGS: begin
                        st_nxt.rdata[7:0] = st_r.pending_flags;
                        st_nxt.pending_flags = '0;
                     end
                     IDX_CHANNEL_FOUND: begin
                        st_nxt.rdata[1:0] = st_r.channel_code;
                     end
                     IDX_CHIP_MODE_FIRST, IDX_CHIP_MODE_SECOND, IDX_SUPPRESS_BITS,
                     IDX_POLLING_CTRL: begin
                        st_nxt.rresp = RESP_OKAY; // Write-only, reads zero
                     end
                     default: begin
                        st_nxt.rresp = RESP_SLVERR;
                     end
                  endcase
               end
            end
            RD_DATA: begin
               if (s_axi_rready) begin
                  st_nxt.rd_state = RD_IDLE;
               end
            end
            default: begin
               st_nxt.rd_state = RD_IDLE;
            end
         endcase

         // New events set flags, winning over a read clear
         st_nxt.pending_flags = st_nxt.pending_flags | event_pulse;

         // Channel code caught on a self-polling wake-up
         if (wakeup_found && st_r.chip_mode_first[BIT_OPERATING_MODE]) begin
            st_nxt.channel_code = wakeup_channel;
         end

         // Mode controls
         st_nxt.ctrl.operating_mode_select = st_r.chip_mode_first[BIT_OPERATING_MODE];
         st_nxt.ctrl.config_hold = cms[BIT_CONFIG_HOLD] &&
            !st_r.chip_mode_first[BIT_OPERATING_MODE];
         st_nxt.ctrl.crystal_trim_enable = cms[BIT_XTAL_TRIM];
         st_nxt.ctrl.queue_init_pulse = frame_start && cms[BIT_QUEUE_INIT];
         st_nxt.ctrl.continuous_wakeup_search = pol[BIT_CONT_SEARCH];
         st_nxt.ctrl.polling_active_idle_enable = pol[BIT_ACTIVE_IDLE];
         // Reserved scheme falls back to constant on/off
         if (pol[SCHEME_MSB:SCHEME_LSB] == SCHEME_RESERVED) begin
            st_nxt.ctrl.polling_scheme = SCHEME_CONST_ON_OFF;
         end else begin
            st_nxt.ctrl.polling_scheme = pol[SCHEME_MSB:SCHEME_LSB];
         end

         // Shared pin functions
         st_nxt.pins.clock_or_data = cms[BIT_CLK_DATA_SEL] ? rx_data : clock_output_src;
         st_nxt.pins.interrupt_or_strobe = cms[BIT_IRQ_STROBE_SEL] ? rx_data_strobe :
            irq_pin_level;
         st_nxt.pins.running_or_data = cms[BIT_RUN_DATA_SEL] ? rx_data : rx_running;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r.wr_state <= WR_IDLE;
         st_r.wr_idx <= '0;
         st_r.wr_data <= '0;
         st_r.wr_strobe <= 1'b0;
         st_r.bresp <= RESP_OKAY;
         st_r.rd_state <= RD_IDLE;
         st_r.rdata <= '0;
         st_r.rresp <= RESP_OKAY;
         st_r.chip_mode_first <= RST_CHIP_MODE_FIRST;
         st_r.chip_mode_second <= RST_CHIP_MODE_SECOND;
         st_r.pending_flags <= RST_PENDING_FLAGS;
         st_r.suppress_bits <= RST_SUPPRESS_BITS;
         st_r.channel_code <= RST_CHANNEL_CODE;
         st_r.polling_ctrl <= RST_POLLING_CTRL;
         st_r.pins <= '0; // Interrupt shown active low at reset
         st_r.ctrl <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule // rmir_regs
`default_nettype wire

// >>> testbench/rmir_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module rmir_regs_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rmir_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [rmir_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side
   input wire logic frame_start,
   input wire rmir_pkg::rmir_ctrl_s mode_ctrl
);
   import rmir_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   // Bus timing
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rd_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_stand: assert property (p_rd_stand) else $error("read data dropped");
   property p_wr_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   a_wr_stand: assert property (p_wr_stand) else $error("write answer dropped");
   property p_ar_refuse;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_refuse: assert property (p_ar_refuse) else $error("read taken while busy");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
         |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

   // Mode controls
   property p_hold_mode;
      mode_ctrl.config_hold |-> !mode_ctrl.operating_mode_select;
   endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("hold outside slave");
   property p_queue_init;
      mode_ctrl.queue_init_pulse |-> $past(frame_start);
   endproperty
   a_queue_init: assert property (p_queue_init) else $error("stray queue init");
   property p_scheme;
      mode_ctrl.polling_scheme != SCHEME_RESERVED;
   endproperty
   a_scheme: assert property (p_scheme) else $error("reserved scheme out");

   // Main scenarios
   c_read: cover property (s_axi_arvalid && s_axi_arready);
   c_queue: cover property (mode_ctrl.queue_init_pulse);
   c_hold: cover property (mode_ctrl.config_hold);
endmodule // rmir_regs_asserts
bind rmir_regs rmir_regs_asserts chk_u (.ref_clk(ref_clk), .resetn(resetn),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .frame_start(frame_start), .mode_ctrl(mode_ctrl));
`default_nettype wire

// >>> testbench/rmir_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmir_core_model (
   // Clock
   input wire logic ref_clk,
   // Events towards the block
   output var rmir_pkg::rmir_evt_s event_pulse,
   output var logic wakeup_found,
   output var logic [1:0] wakeup_channel,
   output var logic frame_start,
   // Pin sources, clock, data, strobe, running
   output var logic [3:0] srcs
);
   import rmir_pkg::*;
   // Quiet at start
   initial begin
      event_pulse = '0;
      wakeup_found = 1'b0;
      wakeup_channel = 2'h0;
      frame_start = 1'b0;
      srcs = 4'h0;
   end
   // One-cycle event pulse
   task automatic pulse(input logic [7:0] v);
      @(posedge ref_clk);
      event_pulse <= v;
      @(posedge ref_clk);
      event_pulse <= '0;
   endtask
   // Wake-up report, code scrambled once the pulse ends
   task automatic wake(input logic [1:0] c);
      @(posedge ref_clk);
      wakeup_found <= 1'b1;
      wakeup_channel <= c;
      @(posedge ref_clk);
      wakeup_found <= 1'b0;
      wakeup_channel <= ~c;
   endtask
   // One-cycle frame start
   task automatic frame;
      @(posedge ref_clk);
      frame_start <= 1'b1;
      @(posedge ref_clk);
      frame_start <= 1'b0;
   endtask
   // Static pin sources
   task automatic src(input logic [3:0] v);
      @(posedge ref_clk);
      srcs <= v;
   endtask
endmodule // rmir_core_model
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rmir_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic clk_en = 1'b1;
   logic [3:0] wstrb = 4'h1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, wk, fs;
   logic [1:0] bresp, rresp, wch;
   logic [31:0] rdata;
   logic [3:0] srcs;
   rmir_evt_s evt;
   rmir_ctrl_s mc;
   rmir_pins_s pd;
   int miscompares = 0, check_count = 0;

   // Clock
   always #20 ref_clk = ~ref_clk;

   rmir_regs dut_u (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_pulse(evt), .wakeup_found(wk),
      .wakeup_channel(wch), .frame_start(fs), .clock_output_src(srcs[3]), .rx_data(srcs[2]),
      .rx_data_strobe(srcs[1]), .rx_running(srcs[0]), .mode_ctrl(mc), .pin_drive(pd));
   rmir_core_model core_u (.ref_clk(ref_clk), .event_pulse(evt), .wakeup_found(wk),
      .wakeup_channel(wch), .frame_start(fs), .srcs(srcs));

   // Comparison and closing
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tmo(input int n);
      if (n == 50) begin
         chk(32'h0, 32'h1);
         finish_test();
      end
   endtask
   task automatic nx;
      repeat (2) @(negedge ref_clk);
   endtask
   // Bus write, readys sampled before the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic ta, tw, tb;
      logic [1:0] r;
      int n;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         tb = bvalid;
         r = bresp;
         @(posedge ref_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb) break;
      end
      bready <= 1'b0;
      tmo(n);
      chk({30'h0, r}, {30'h0, er});
   endtask
   // Bus read with expected data and answer
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      logic tr, tv;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      @(posedge ref_clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 50; n++) begin
         @(negedge ref_clk);
         tr = arvalid & arready;
         tv = rvalid;
         d = rdata;
         r = rresp;
         @(posedge ref_clk);
         if (tr) arvalid <= 1'b0;
         if (tv) break;
      end
      rready <= 1'b0;
      tmo(n);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // Main sequence
   initial begin
      logic [3:0] pe;
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      nx();
      chk({31'h0, pd.interrupt_or_strobe}, 32'h0);
      rd(8'h10, 32'hff);
      rd(8'h10, 32'h0);
      rd(8'h18, 32'h0);
      nx();
      chk({31'h0, pd.interrupt_or_strobe}, 32'h1);
      $display("reset done");
      for (int i = 0; i < 8; i++) begin
         wr(8'h14, 8'h1 << i);
         core_u.pulse(8'h1 << i);
         nx();
         chk({31'h0, pd.interrupt_or_strobe}, 32'h1);
         rd(8'h10, 32'h1 << i);
         wr(8'h14, 8'h0);
         core_u.pulse(8'h1 << i);
         nx();
         chk({31'h0, pd.interrupt_or_strobe}, 32'h0);
         rd(8'h10, 32'h1 << i);
      end
      wr(8'h0c, 8'h20);
      nx();
      chk({31'h0, pd.interrupt_or_strobe}, 32'h0);
      core_u.pulse(8'h80);
      nx();
      chk({31'h0, pd.interrupt_or_strobe}, 32'h1);
      rd(8'h10, 32'h80);
      // Frozen block ignores an event
      @(posedge ref_clk);
      clk_en <= 1'b0;
      core_u.pulse(8'h01);
      nx();
      chk({31'h0, pd.interrupt_or_strobe}, 32'h0);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      rd(8'h10, 32'h0);
      $display("events done");
      core_u.src(4'h9);
      for (int s = 0; s < 8; s++) begin
         wr(8'h0c, 8'(s));
         nx();
         chk({29'h0, pd}, {29'h0, ~3'(s)});
      end
      wr(8'h0c, 8'h58);
      core_u.frame();
      @(negedge ref_clk);
      chk({29'h0, mc.config_hold, mc.crystal_trim_enable,
         mc.queue_init_pulse}, 32'h7);
      wr(8'h0c, 8'h40);
      core_u.frame();
      @(negedge ref_clk);
      chk({30'h0, mc.crystal_trim_enable, mc.queue_init_pulse}, 32'h0);
      wr(8'h08, 8'h01);
      nx();
      chk({30'h0, mc.operating_mode_select, mc.config_hold}, 32'h2);
      // Host never programs the reserved scheme
      for (int v = 0; v < 16; v++) begin
         pe = 4'(v);
         if (pe[1:0] != SCHEME_RESERVED) begin
            wr(8'h1c, 8'(v));
            nx();
            chk({28'h0, mc.continuous_wakeup_search, mc.polling_active_idle_enable,
               mc.polling_scheme}, {28'h0, pe});
         end
      end
      // Byte strobe low leaves the register alone
      @(posedge ref_clk);
      wstrb <= 4'h0;
      wr(8'h1c, 8'h00);
      wstrb <= 4'h1;
      nx();
      chk({28'h0, mc.continuous_wakeup_search, mc.polling_active_idle_enable,
         mc.polling_scheme}, 32'he);
      $display("modes done");
      for (int c = 1; c < 4; c++) begin
         core_u.wake(2'(c));
         rd(8'h18, 32'(c));
      end
      wr(8'h08, 8'h00);
      core_u.wake(2'h1);
      rd(8'h18, 32'h3);
      rd(8'h3c, 32'h0, RESP_SLVERR);
      wr(8'h3c, 8'h55, RESP_SLVERR);
      wr(8'h18, 8'h01);
      rd(8'h18, 32'h3);
      $display("channel done");
      finish_test();
   end
endmodule // testbench
`default_nettype wire
